// ### dbtw_exec.sv
// execution unit for decrement, skip-decrement, page branch and table write
// Overview of operation
// - decrements put result in working register if d=0, file register if d=1
// - skip-if-nonzero decrement skips next instruction when result is not zero
// - taken skip discards prefetched word and runs a forced no-op cycle
// - page branch loads 13-bit literal into program counter bits 12..0
// - after branch, upper eight program counter bits are copied to pc high latch
// - page branch always takes two cycles, second is a forced no-op
// - table write loads file value into latch low byte (t=0) or high byte (t=1)
// - whole table latch is written to program memory at table pointer
// - table pointer increments by one after write when i=1, else unchanged
// - table write to external program memory completes in two cycles
// - table write to internal memory runs until an interrupt terminates it
`timescale 1ns/10ps
module dbtw_exec #(
  parameter int PC_W   = 16,
  parameter int DATA_W = 8
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                instr_valid,
  input  wire logic [15:0]         instr_word,
  input  wire logic [DATA_W-1:0]   file_rdata,
  input  wire logic                tptr_external,
  input  wire logic                irq_pending,
  output logic                     instr_accept,
  output logic                     discard_fetch,
  output logic [PC_W-1:0]          pc_q,
  output logic [7:0]               pc_high_latch_q,
  output logic [DATA_W-1:0]        wreg_q,
  output logic                     wreg_we_q,
  output logic [DATA_W-1:0]        file_wdata_q,
  output logic                     file_we_q,
  output logic [3:0]               flags_q,
  output logic                     flags_we_q,
  output logic [15:0]              table_latch_q,
  output logic [15:0]              table_pointer_q,
  output logic                     pmem_we_q,
  output logic [15:0]              pmem_addr_q,
  output logic [15:0]              pmem_wdata_q
);
  import dbtw_pkg::*;

  initial begin
    if (PC_W != 16 || DATA_W != 8) begin
      $error("dbtw_exec supports only PC_W=16 and DATA_W=8");
    end
  end

  dbtw_state_type state_q;

  // decode helpers
  function automatic logic is_dec(input logic [15:0] w);
    is_dec = (w[15:OPC7_LSB] == DEC_FILE_OPC) || (w[15:OPC7_LSB] == DSZ_OPC)
          || (w[15:OPC7_LSB] == DSNZ_OPC);
  endfunction

  logic take;
  logic op_dec;
  logic op_dsz;
  logic op_dsnz;
  logic op_br;
  logic op_tw;
  logic [DATA_W-1:0] dec_res;
  logic skip;

  assign take    = instr_valid && (state_q == DBTW_EXEC);
  assign op_dec  = take && is_dec(instr_word);
  assign op_dsz  = take && (instr_word[15:OPC7_LSB] == DSZ_OPC);
  assign op_dsnz = take && (instr_word[15:OPC7_LSB] == DSNZ_OPC);
  assign op_br   = take && (instr_word[15:OPC3_LSB] == BRANCH_OPC);
  assign op_tw   = take && (instr_word[15:OPC6_LSB] == TWRITE_OPC);
  assign dec_res = file_rdata - 8'h01;
  // skip decision: zero for one variant, nonzero for the other
  assign skip    = (op_dsz && dec_res == 8'h00)
                || (op_dsnz && dec_res != 8'h00);

  // a new instruction is accepted only in the execute state
  assign instr_accept  = take;
  assign discard_fetch = skip || op_br;

  // sequencing: forced no-op after skip or branch, long stall for internal writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= DBTW_EXEC;
    end else begin
      case (state_q)
        DBTW_EXEC: begin
          if (skip || op_br) begin
            state_q <= DBTW_FNOP;
          end else if (op_tw) begin
            state_q <= DBTW_TWRITE;
          end
        end
        DBTW_FNOP: state_q <= DBTW_EXEC;
        DBTW_TWRITE: begin
          // external memory: done in the second cycle; internal: wait for interrupt
          if (tptr_external || irq_pending) begin
            state_q <= DBTW_EXEC;
          end
        end
        default: state_q <= DBTW_EXEC;
      endcase
    end
  end

  // destination write-back of the decrement result
  always_ff @(posedge mclk) begin
    if (reset) begin
      wreg_q       <= '0;
      wreg_we_q    <= 1'b0;
      file_wdata_q <= '0;
      file_we_q    <= 1'b0;
    end else begin
      wreg_we_q <= op_dec && !instr_word[DEST_BIT];
      file_we_q <= op_dec && instr_word[DEST_BIT];
      if (op_dec && !instr_word[DEST_BIT]) begin
        wreg_q <= dec_res;
      end
      if (op_dec) begin
        file_wdata_q <= dec_res;
      end
    end
  end

  // status flags only for the plain decrement; borrow shows as carry clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_q    <= 4'h0;
      flags_we_q <= 1'b0;
    end else begin
      flags_we_q <= op_dec && !op_dsz && !op_dsnz;
      if (op_dec && !op_dsz && !op_dsnz) begin
        flags_q[FLAG_Z]  <= (dec_res == 8'h00);
        flags_q[FLAG_C]  <= (file_rdata != 8'h00);
        flags_q[FLAG_DC] <= (file_rdata[3:0] != 4'h0);
        flags_q[FLAG_OV] <= (file_rdata == 8'h80);
      end
    end
  end

  // program counter: sequential advance, branch into the current 8k page
  always_ff @(posedge mclk) begin
    if (reset) begin
      pc_q            <= PC_RST;
      pc_high_latch_q <= PCLH_RST;
    end else if (op_br) begin
      pc_q            <= {pc_q[15:LIT_W], instr_word[LIT_W-1:0]};
      pc_high_latch_q <= pc_q[15:8] & 8'hE0 | {3'b000, instr_word[12:8]};
    end else if (take || state_q == DBTW_FNOP) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  // table latch fill, then program memory write with optional pointer step
  always_ff @(posedge mclk) begin
    if (reset) begin
      table_latch_q   <= TLAT_RST;
      table_pointer_q <= TPTR_RST;
      pmem_we_q       <= 1'b0;
      pmem_addr_q     <= 16'h0000;
      pmem_wdata_q    <= 16'h0000;
    end else begin
      pmem_we_q <= 1'b0;
      if (op_tw) begin
        if (instr_word[TSEL_BIT]) begin
          table_latch_q[15:8] <= file_rdata;
        end else begin
          table_latch_q[7:0] <= file_rdata;
        end
        pmem_we_q    <= 1'b1;
        pmem_addr_q  <= table_pointer_q;
        pmem_wdata_q <= instr_word[TSEL_BIT] ? {file_rdata, table_latch_q[7:0]}
                                             : {table_latch_q[15:8], file_rdata};
        if (instr_word[INC_BIT]) begin
          table_pointer_q <= table_pointer_q + 16'h0001;
        end
      end else if (state_q == DBTW_TWRITE && !tptr_external && !irq_pending) begin
        pmem_we_q <= 1'b1;
      end
    end
  end

  // assertions
  skip_nop_a: assert property (@(posedge mclk) disable iff (reset)
    skip |=> state_q == DBTW_FNOP && !instr_accept ##1 state_q == DBTW_EXEC)
    else $error("skip did not insert exactly one no-op");
  dsnz_skip_a: assert property (@(posedge mclk) disable iff (reset)
    op_dsnz && file_rdata != 8'h01 |-> discard_fetch)
    else $error("nonzero result did not skip");
  dsz_skip_a: assert property (@(posedge mclk) disable iff (reset)
    op_dsz |-> discard_fetch == (file_rdata == 8'h01))
    else $error("zero result skip wrong");
  dest_sel_a: assert property (@(posedge mclk) disable iff (reset)
    op_dec |=> (wreg_we_q != file_we_q) && file_wdata_q == $past(file_rdata) - 8'h01)
    else $error("decrement destination wrong");
  branch_pc_a: assert property (@(posedge mclk) disable iff (reset)
    op_br |=> pc_q[12:0] == $past(instr_word[12:0]) && pc_high_latch_q[4:0] == pc_q[12:8])
    else $error("branch target or latch wrong");
  branch_two_a: assert property (@(posedge mclk) disable iff (reset)
    op_br |=> !instr_accept ##1 state_q == DBTW_EXEC)
    else $error("branch not two cycles");
  flags_keep_a: assert property (@(posedge mclk) disable iff (reset)
    (op_dsz || op_dsnz) |=> !flags_we_q && $stable(flags_q))
    else $error("skip decrement touched flags");
  tw_latch_a: assert property (@(posedge mclk) disable iff (reset)
    op_tw |=> pmem_we_q && pmem_wdata_q == table_latch_q && pmem_addr_q == $past(table_pointer_q))
    else $error("table write data or address wrong");
  tw_inc_a: assert property (@(posedge mclk) disable iff (reset)
    op_tw |=> table_pointer_q == $past(table_pointer_q) + {15'h0000, $past(instr_word[INC_BIT])})
    else $error("table pointer step wrong");
  tw_ext_a: assert property (@(posedge mclk) disable iff (reset)
    op_tw && tptr_external |=> tptr_external |-> ##1 state_q == DBTW_EXEC)
    else $error("external table write not two cycles");
  tw_int_a: assert property (@(posedge mclk) disable iff (reset)
    state_q == DBTW_TWRITE && !tptr_external && !irq_pending |=> state_q == DBTW_TWRITE)
    else $error("internal table write ended without interrupt");

  // pipeline picture for the checks below:
  //   edge n   : instruction is taken while instr_accept is high
  //   edge n+1 : registered results and write enables show for one cycle
  //   edge n+1 : next instruction too, unless a forced no-op or a write wait
  //              stands in the execute slot
  // the fetch side relies on discard_fetch in the cycle of the take, so
  // that flag is combinational, like instr_accept; every other output is a flop.
  // a limitation: the file register value must be valid in the same cycle
  // as the take, there is no read stage of its own in this unit.

  // destination select, checked for each polarity of the destination bit
  dec_wreg_a: assert property (@(posedge mclk) disable iff (reset)
    op_dec && !instr_word[DEST_BIT] |=> wreg_we_q && wreg_q == $past(file_rdata) - 8'h01)
    else $error("decrement result missing in working register");
  dec_file_a: assert property (@(posedge mclk) disable iff (reset)
    op_dec && instr_word[DEST_BIT] |=> file_we_q && !wreg_we_q)
    else $error("decrement result missing in file register");

  // the nonzero variant must not skip on a zero result
  dsnz_stay_a: assert property (@(posedge mclk) disable iff (reset)
    op_dsnz && file_rdata == 8'h01 |-> !discard_fetch)
    else $error("zero result skipped on nonzero variant");

  // no instruction is taken while the forced no-op holds the slot
  fnop_refuse_a: assert property (@(posedge mclk) disable iff (reset)
    state_q == DBTW_FNOP |-> !instr_accept)
    else $error("instruction taken during forced no-op");

  // the high latch follows the upper byte of the new program counter
  pclh_copy_a: assert property (@(posedge mclk) disable iff (reset)
    op_br |=> pc_high_latch_q == pc_q[15:8])
    else $error("pc high latch differs from upper pc byte");

  // the branch always throws away the prefetched word
  br_discard_a: assert property (@(posedge mclk) disable iff (reset)
    op_br |-> discard_fetch)
    else $error("branch kept the prefetched word");

  // byte select of the table latch fill
  tw_low_a: assert property (@(posedge mclk) disable iff (reset)
    op_tw && !instr_word[TSEL_BIT] |=> table_latch_q[7:0] == $past(file_rdata))
    else $error("table latch low byte not loaded");
  tw_high_a: assert property (@(posedge mclk) disable iff (reset)
    op_tw && instr_word[TSEL_BIT] |=> table_latch_q[15:8] == $past(file_rdata))
    else $error("table latch high byte not loaded");

  // the cycle after a table write is never free for a new instruction
  tw_wait_a: assert property (@(posedge mclk) disable iff (reset)
    op_tw |=> !instr_accept)
    else $error("table write shorter than two cycles");

  // an interrupt ends the long internal write at the next edge
  tw_irq_end_a: assert property (@(posedge mclk) disable iff (reset)
    state_q == DBTW_TWRITE && irq_pending |=> state_q == DBTW_EXEC)
    else $error("interrupt did not end internal table write");

  // flag update of the plain decrement, zero flag as the sample
  flags_z_a: assert property (@(posedge mclk) disable iff (reset)
    op_dec && !op_dsz && !op_dsnz |=> flags_we_q && flags_q[FLAG_Z] == ($past(file_rdata) == 8'h01))
    else $error("plain decrement zero flag wrong");

  // the skip variants use the write-back path like the plain decrement but leave the flags alone;
  // a trade-off: sharing one write-back flop set keeps the unit small but
  // means only one decrement result can be in flight at a time, which the
  // one-instruction-per-cycle take already guarantees.
endmodule

// ### dbtw_pkg.sv
// package: encodings, field positions and widths for the decrement/branch/table-write unit
package dbtw_pkg;
  // opcode field values (upper bits of the 16-bit instruction word)
  localparam logic [6:0] DEC_FILE_OPC = 7'h03; // 0000_011d
  localparam logic [6:0] DSZ_OPC    = 7'h0B; // 0001_011d
  localparam logic [6:0] DSNZ_OPC   = 7'h13; // 0010_011d
  localparam logic [2:0] BRANCH_OPC = 3'h6;  // 110k
  localparam logic [5:0] TWRITE_OPC = 6'h2B; // 1010_11ti
  // field positions
  localparam int OPC7_LSB = 9;
  localparam int OPC3_LSB = 13;
  localparam int OPC6_LSB = 10;
  localparam int DEST_BIT = 8;
  localparam int TSEL_BIT = 9;
  localparam int INC_BIT  = 8;
  localparam int LIT_W    = 13;
  // reset values
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  PCLH_RST  = 8'h00;
  localparam logic [15:0] TLAT_RST  = 16'h0000;
  localparam logic [15:0] TPTR_RST  = 16'h0000;
  // flag vector layout {ov, z, dc, c}
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  typedef enum logic [1:0] {
    DBTW_EXEC,
    DBTW_FNOP,
    DBTW_TWRITE
  } dbtw_state_type;
endpackage

// ### dbtw_mem_model.sv
// partner model: one data register cell and the program memory write port
`timescale 1ns/10ps
module dbtw_mem_model (
  input  wire logic        mclk,
  input  wire logic        preset_en,
  input  wire logic [7:0]  preset_val,
  input  wire logic        file_we_q,
  input  wire logic [7:0]  file_wdata_q,
  input  wire logic        pmem_we_q,
  input  wire logic [15:0] pmem_addr_q,
  input  wire logic [15:0] pmem_wdata_q,
  output logic [7:0]       file_rdata,
  output logic [15:0]      mem_word,
  output logic [15:0]      mem_addr
);
  logic [7:0] cell_q;
  // read is same-cycle; a preset stands in for other registers of the file
  assign file_rdata = preset_en ? preset_val : cell_q;
  // write-back of a decremented value
  always_ff @(posedge mclk) begin
    if (file_we_q) begin
      cell_q <= file_wdata_q;
    end
  end
  // keeps only the last word, enough to judge one write at a time
  always_ff @(posedge mclk) begin
    if (pmem_we_q) begin
      mem_word <= pmem_wdata_q;
      mem_addr <= pmem_addr_q;
    end
  end
endmodule

// ### decrement_branch_tablewrite_exec_bench.sv
// self-checking bench for the decrement, page branch and table write unit
`timescale 1ns/10ps
module decrement_branch_tablewrite_exec_bench;
  import dbtw_pkg::*;
  logic        mclk, reset, instr_valid, tptr_external, irq_pending, preset_en, disc_s;
  logic        instr_accept, discard_fetch, wreg_we_q, file_we_q, flags_we_q, pmem_we_q;
  logic [15:0] instr_word, pc_q, table_latch_q, table_pointer_q, pmem_addr_q, pmem_wdata_q;
  logic [15:0] mem_word, mem_addr;
  logic [7:0]  preset_val, file_rdata, pc_high_latch_q, wreg_q, file_wdata_q;
  logic [3:0]  flags_q;
  int          num_errors = 0, n_tests = 0, cycles = 0;
  dbtw_exec dbtw_exec_inst (.mclk(mclk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_rdata(file_rdata), .tptr_external(tptr_external),
    .irq_pending(irq_pending), .instr_accept(instr_accept), .discard_fetch(discard_fetch),
    .pc_q(pc_q), .pc_high_latch_q(pc_high_latch_q), .wreg_q(wreg_q), .wreg_we_q(wreg_we_q),
    .file_wdata_q(file_wdata_q), .file_we_q(file_we_q), .flags_q(flags_q),
    .flags_we_q(flags_we_q), .table_latch_q(table_latch_q), .table_pointer_q(table_pointer_q),
    .pmem_we_q(pmem_we_q), .pmem_addr_q(pmem_addr_q), .pmem_wdata_q(pmem_wdata_q));
  dbtw_mem_model dbtw_mem_model_inst (.mclk(mclk), .preset_en(preset_en),
    .preset_val(preset_val), .file_we_q(file_we_q), .file_wdata_q(file_wdata_q),
    .pmem_we_q(pmem_we_q), .pmem_addr_q(pmem_addr_q), .pmem_wdata_q(pmem_wdata_q),
    .file_rdata(file_rdata), .mem_word(mem_word), .mem_addr(mem_addr));
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // waits out refused cycles, then holds one instruction across one edge
  task automatic issue(input logic [15:0] w, input logic pe, input logic [7:0] v);
    instr_valid = 1'b1;
    instr_word = w;
    preset_en = pe;
    preset_val = v;
    #1;
    for (int i = 0; i < 8 && instr_accept !== 1'b1; i++) begin
      @(negedge mclk);
      #1;
    end
    disc_s = discard_fetch;
    @(negedge mclk);
    instr_valid = 1'b0;
    preset_en = 1'b0;
  endtask
  // offers a harmless word for one edge and reports whether it was taken
  task automatic probe(output logic a);
    instr_valid = 1'b1;
    instr_word = 16'h0000;
    #1 a = instr_accept;
    @(negedge mclk);
    instr_valid = 1'b0;
  endtask
  task automatic t_dec_file();
    logic a;
    issue({DEC_FILE_OPC, 1'b0, 8'h00}, 1'b1, 8'h01);
    chk(16'h0200, {7'h00, wreg_we_q, file_we_q, wreg_q});
    chk(16'h0017, {11'h000, flags_we_q, flags_q});
    probe(a);
    chk(16'h0001, 16'(a));
    issue({DEC_FILE_OPC, 1'b1, 8'h00}, 1'b1, 8'h80);
    chk(16'h017F, {7'h00, file_we_q, file_wdata_q});
    chk(16'h0019, {11'h000, flags_we_q, flags_q});
    $display("test plain decrement done");
  endtask
  // v is the value the unit reads; sk says whether a skip is due
  task automatic skip_case(input logic [6:0] opc, input logic pe, input logic [7:0] v,
                           input logic sk);
    logic a;
    issue({opc, 1'b0, 8'h00}, pe, v);
    chk(16'({sk, 1'b0, v - 8'h01}), 16'({disc_s, flags_we_q, wreg_q}));
    probe(a);
    chk(16'(!sk), 16'(a));
  endtask
  task automatic t_skip();
    issue({DEC_FILE_OPC, 1'b1, 8'h00}, 1'b1, 8'h02);
    @(negedge mclk);
    skip_case(DSZ_OPC, 1'b0, 8'h01, 1'b1);
    skip_case(DSZ_OPC, 1'b1, 8'h05, 1'b0);
    skip_case(DSNZ_OPC, 1'b1, 8'h05, 1'b1);
    skip_case(DSNZ_OPC, 1'b1, 8'h01, 1'b0);
    $display("test skip done");
  endtask
  task automatic t_branch();
    logic a;
    issue({BRANCH_OPC, 13'h1ABC}, 1'b0, 8'h00);
    chk(16'h1ABC, pc_q);
    chk(16'h001A, 16'(pc_high_latch_q));
    probe(a);
    chk(16'h0002, 16'({disc_s, a}));
    probe(a);
    chk(16'h0001, 16'(a));
    $display("test branch done");
  endtask
  task automatic t_twrite();
    logic a;
    tptr_external = 1'b1;
    issue({TWRITE_OPC, 2'b00, 8'h00}, 1'b1, 8'h34);
    chk(16'h0034, table_latch_q);
    chk(16'h0000, 16'({pmem_we_q, instr_accept}) ^ 16'h0002 | table_pointer_q);
    probe(a);
    chk(16'h0000, 16'(a));
    probe(a);
    chk(16'h0001, 16'(a));
    issue({TWRITE_OPC, 2'b11, 8'h00}, 1'b1, 8'h12);
    chk(16'h1234, pmem_wdata_q);
    chk(16'h0001, table_pointer_q);
    @(negedge mclk);
    chk(16'h1234, mem_word);
    chk(16'h0000, mem_addr);
    tptr_external = 1'b0;
    issue({TWRITE_OPC, 2'b10, 8'h00}, 1'b1, 8'h99);
    repeat (5) @(negedge mclk);
    probe(a);
    chk(16'h0002, 16'({pmem_we_q, a}));
    irq_pending = 1'b1;
    @(negedge mclk);
    irq_pending = 1'b0;
    probe(a);
    chk(16'h0001, 16'({pmem_we_q, a}));
    chk(16'h9934, table_latch_q);
    chk(16'h0001, table_pointer_q);
    $display("test table write done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // hang guard: the whole sequence needs well under a hundred cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    {reset, instr_valid, tptr_external, irq_pending, preset_en} = 5'b10000;
    {instr_word, preset_val} = 24'h0000_00;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    chk(PC_RST, pc_q);
    chk(TPTR_RST, table_pointer_q);
    t_dec_file();
    t_skip();
    t_branch();
    t_twrite();
    results();
  end
endmodule
